// ### design/sci_consts.svh
/*
  Constants for the sync and sampling-clock input control block: register byte
  addresses, field positions, reset values, input ordering and timing counts.
  Assumes inclusion by bare name from each design file; definitions only.
*/
`ifndef SCI_CONSTS_SVH
`define SCI_CONSTS_SVH

// register byte addresses on the 32-bit bus
`define SCI_ADDR_CTRL      8'h00
`define SCI_ADDR_CLAMP     8'h04
`define SCI_ADDR_PLL       8'h08
`define SCI_ADDR_STATUS    8'h0C
`define SCI_IDX_SYNCPOL    8'h0F
`define SCI_ADDR_SYNCPOL   (`SCI_IDX_SYNCPOL << 2)

// control and sync polarity register fields
`define SCI_CTRL_PD        0
`define SCI_CTRL_EXTERNAL_CLAMP_ENABLE   1
`define SCI_CTRL_CLMPPOL   2
`define SCI_CTRL_COASTPOL  3
`define SCI_CTRL_EXTCK     4
`define SCI_CTRL_HSPOL     5
`define SCI_CTRL_SLICESEL  6
`define SCI_SYNCPOL_BIT    7

// reset values
`define SCI_RST_EXTERNAL_CLAMP_ENABLE    1'b0
`define SCI_RST_CLMPPOL    1'b1
`define SCI_RST_COASTPOL   1'b1
`define SCI_RST_HSPOL      1'b1
`define SCI_RST_LSPOL      1'b1
`define SCI_RST_CLAMP_DLY  8'h04
`define SCI_RST_CLAMP_DUR  8'h08
`define SCI_RST_HS_WIDTH   8'h10
`define SCI_RST_PERIOD     12'h009

// pin input positions in the synchroniser vector
`define SCI_SYNC_W         7
`define SCI_IN_LS          0
`define SCI_IN_DE          1
`define SCI_IN_CLAMP       2
`define SCI_IN_COAST       3
`define SCI_IN_SOG         4
`define SCI_IN_EXTCK       5
`define SCI_IN_INV         6

// timing
`define SCI_CLK_MHZ        100
`define SCI_ACT_TIMEOUT_US 100

`endif

// ### design/sci_pkg.sv
/*
  Types of the sync and sampling-clock input control block.
  Assumes sci_consts.svh is reachable on the include path.
*/
`default_nettype none
`include "sci_consts.svh"

package sci_pkg;

  typedef enum logic [1:0] {CLAMP_IDLE, CLAMP_DELAY, CLAMP_HOLD} sci_clamp_t;

  typedef enum logic [2:0] {SEL_CTRL, SEL_CLAMP, SEL_PLL, SEL_STATUS, SEL_SYNCPOL,
                            SEL_NONE} sci_sel_t;

  typedef struct packed {
    logic        pd;
    logic        ext_clamp_en;
    logic        clamp_pol;
    logic        coast_pol;
    logic        ext_clk_sel;
    logic        hs_pol;
    logic        slicer_sel;
    logic        ls_pol;
    logic [7:0]  clamp_dly;
    logic [7:0]  clamp_dur;
    logic [7:0]  hs_width;
    logic [11:0] period;
  } sci_cfg_t;

  typedef struct packed {
    logic [`SCI_SYNC_W-1:0] meta;
    logic [`SCI_SYNC_W-1:0] stage;
  } sci_sync_t;

  typedef struct packed {
    logic [11:0] cnt;
    logic        ext_prev;
    logic        en;
  } sci_gen_t;

endpackage : sci_pkg

`default_nettype wire

// ### design/sci_sync2.sv
/*
  Two-flop synchroniser for every pin input of the block.
  Assumes all inputs are asynchronous levels slower than core_clk.
*/
`default_nettype none
`include "sci_consts.svh"

module sci_sync2
  import sci_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   nrst,
  input  wire logic [`SCI_SYNC_W-1:0] din,
  output logic      [`SCI_SYNC_W-1:0] dout
);

  sci_sync_t q;
  sci_sync_t d;

  // first stage feeds only the second stage
  always_comb begin
    d       = q;
    d.meta  = din;
    d.stage = q.meta;
  end

  // state register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.stage;

endmodule : sci_sync2

`default_nettype wire

// ### design/sci_pixgen.sv
/*
  Pixel sampling clock generator: one-cycle sample enable, either from a
  divider that realigns on line sync or from the external clock pin.
  Assumes ext_clk_s is already synchronised to core_clk.
*/
`default_nettype none
`include "sci_consts.svh"

module sci_pixgen
  import sci_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [11:0] period,
  input  wire logic        resync,
  input  wire logic        ext_sel,
  input  wire logic        ext_clk_s,
  input  wire logic        invert,
  output logic             pix_en
);

  sci_gen_t q;
  sci_gen_t d;
  logic     int_tick;
  logic     ext_tick;

  // divider, edge pick and clock source select
  always_comb begin
    d          = q;
    d.ext_prev = ext_clk_s;
    if (resync) begin
      d.cnt = 12'h000;
    end else if (q.cnt >= period) begin
      d.cnt = 12'h000;
    end else begin
      d.cnt = q.cnt + 12'h001;
    end
    // [RULE14] half period shift
    int_tick = invert ? (q.cnt == (period >> 1)) : (q.cnt == 12'h000);
    ext_tick = invert ? (~ext_clk_s & q.ext_prev) : (ext_clk_s & ~q.ext_prev);
    // [RULE13] external clock source
    d.en     = ext_sel ? ext_tick : int_tick;
  end

  // state register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pix_en = q.en;

  a_ext_clock_sel: assert property ( // [RULE13]
    @(posedge core_clk) disable iff (!nrst)
    (ext_sel && !invert && ext_clk_s && !q.ext_prev) |=> pix_en)
    else $error("external clock edge gave no sample enable");

endmodule : sci_pixgen

`default_nettype wire

// ### design/sci_top.sv
/*
  Sync and sampling-clock input control: activity detect with data tri-state,
  line-sync edge select, clamp timing, coast, clock select and inversion,
  reconstructed line sync and slicer output, registers over APB.
  Assumes pins are asynchronous, pix_in comes from the converter on core_clk,
  and the bus master keeps APB signalling.
*/
// Chosen here: the address map and register access over APB.
`default_nettype none
`include "sci_consts.svh"

// Operation
// [RULE1] activity comes from line-sync edges or data-enable edges
// [RULE2] activity output low when both idle or in power-down
// [RULE3] pixel data outputs tri-stated whenever activity is low
// [RULE4] line-sync polarity is bit 7 of register index 0x0F
// [RULE5] act on leading line-sync edge only; 0 falling, 1 rising
// [RULE6] external clamp pin used only when its enable is 1; resets 0
// [RULE7] clamp disabled: delay then duration counted from line-sync trailing edge
// [RULE8] clamp pin active level set by clamp polarity bit
// [RULE9] system grounds unused clamp pin and keeps its enable 0
// [RULE10] coast stops generator tracking line sync, keeps frequency and phase
// [RULE11] coast active level set by coast polarity, resets to 1
// [RULE12] system ties unused coast pin to match its polarity setting
// [RULE13] external clock select 1 samples with the external clock pin
// [RULE14] sampling inversion shifts the sampling phase by half a period
// [RULE15] system changes inversion only during blanking
// [RULE16] reconstructed line sync aligned to data clock; polarity, width programmable
// [RULE17] slicer output selects green sync or delayed raw line sync
// [RULE18] green embedded sync appears non-inverted on slicer output
// [RULE19] clamp delay and duration count pixel clocks from programmable fields
module sci_top
  import sci_pkg::*;
#(
  parameter int ACT_TIMEOUT_CYC = `SCI_ACT_TIMEOUT_US * `SCI_CLK_MHZ
)
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        line_sync_in,
  input  wire logic        active_video_flag,
  input  wire logic        clamp_in,
  input  wire logic        coast_in,
  input  wire logic        green_embedded_sync_in,
  input  wire logic        ext_clock_in,
  input  wire logic        sampling_clock_invert,
  input  wire logic [23:0] pix_in,
  output logic             chip_activity_out,
  output logic      [23:0] pix_data_out,
  output logic             pix_data_oe_n,
  output logic             output_data_clock,
  output logic             pix_sample_en,
  output logic             clamp_active_out,
  output logic             line_sync_out,
  output logic             slicer_sync_out
);

  typedef struct packed {
    sci_cfg_t    cfg;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        ls_prev;
    logic        de_prev;
    logic [2:0]  warm;
    logic [15:0] idle_cnt;
    logic        active;
    logic        oe_n;
    logic [23:0] pix;
    logic        dck;
    sci_clamp_t  clamp_st;
    logic [7:0]  clamp_cnt;
    logic        clamp_out;
    logic        hs_pend;
    logic [7:0]  hs_cnt;
    logic        hs_out;
    logic [1:0]  ls_dly;
    logic        slicer;
  } sci_state_t;

  localparam logic [15:0] ACT_CYC = 16'(ACT_TIMEOUT_CYC);

  localparam sci_cfg_t CFG_RST = '{
    pd:           1'b0,
    ext_clamp_en: `SCI_RST_EXTERNAL_CLAMP_ENABLE,
    clamp_pol:    `SCI_RST_CLMPPOL,
    coast_pol:    `SCI_RST_COASTPOL,
    ext_clk_sel:  1'b0,
    hs_pol:       `SCI_RST_HSPOL,
    slicer_sel:   1'b0,
    ls_pol:       `SCI_RST_LSPOL,
    clamp_dly:    `SCI_RST_CLAMP_DLY,
    clamp_dur:    `SCI_RST_CLAMP_DUR,
    hs_width:     `SCI_RST_HS_WIDTH,
    period:       `SCI_RST_PERIOD
  };

  sci_state_t             q;
  sci_state_t             d;
  logic [`SCI_SYNC_W-1:0] pins_s;
  logic                   ls;
  logic                   lead;
  logic                   trail;
  logic                   ev;
  logic                   ext_clamp_act;
  logic                   coast_act;
  logic                   resync;
  logic                   pix_en;
  sci_sel_t               sel;

  // address decode, shared by the read mux and the write path
  function automatic sci_sel_t reg_decode(input logic [7:0] addr);
    unique case (addr)
      `SCI_ADDR_CTRL:    reg_decode = SEL_CTRL;
      `SCI_ADDR_CLAMP:   reg_decode = SEL_CLAMP;
      `SCI_ADDR_PLL:     reg_decode = SEL_PLL;
      `SCI_ADDR_STATUS:  reg_decode = SEL_STATUS;
      `SCI_ADDR_SYNCPOL: reg_decode = SEL_SYNCPOL;
      default:           reg_decode = SEL_NONE;
    endcase
  endfunction : reg_decode

  // pin inputs pass two flops first
  sci_sync2 u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .din      ({sampling_clock_invert, ext_clock_in, green_embedded_sync_in, coast_in,
                clamp_in, active_video_flag, line_sync_in}),
    .dout     (pins_s)
  );

  // sampling clock enable source
  sci_pixgen u_gen (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .period    (q.cfg.period),
    .resync    (resync),
    .ext_sel   (q.cfg.ext_clk_sel),
    .ext_clk_s (pins_s[`SCI_IN_EXTCK]),
    .invert    (pins_s[`SCI_IN_INV]),
    .pix_en    (pix_en)
  );

  // line-sync edges, pin polarities and generator resync
  always_comb begin
    ls            = pins_s[`SCI_IN_LS];
    // [RULE4] [RULE5] leading edge by polarity
    lead          = q.warm[2] & (q.cfg.ls_pol ? (ls & ~q.ls_prev) : (~ls & q.ls_prev));
    trail         = q.warm[2] & (q.cfg.ls_pol ? (~ls & q.ls_prev) : (ls & ~q.ls_prev));
    // [RULE1] either interface shows activity
    ev            = lead | (q.warm[2] & pins_s[`SCI_IN_DE] & ~q.de_prev);
    // [RULE8] clamp pin active level
    ext_clamp_act = pins_s[`SCI_IN_CLAMP] ~^ q.cfg.clamp_pol;
    // [RULE11] coast pin active level
    coast_act     = pins_s[`SCI_IN_COAST] ~^ q.cfg.coast_pol;
    // [RULE10] coast blocks realignment
    resync        = lead & ~coast_act;
    sel           = reg_decode(paddr);
  end

  // next state of the whole block
  always_comb begin
    d         = q;
    d.ls_prev = ls;
    d.de_prev = pins_s[`SCI_IN_DE];
    d.warm    = {q.warm[1:0], 1'b1}; // no edges until the synchroniser holds pin levels

    // bus slave: answer in the first access cycle, unmapped gives an error
    d.pready  = psel & ~penable;
    d.pslverr = psel & ~penable & (sel == SEL_NONE);
    if (psel && !penable) begin
      case (sel)
        SEL_CTRL:    d.prdata = {25'h0000000, q.cfg.slicer_sel, q.cfg.hs_pol,
                                 q.cfg.ext_clk_sel, q.cfg.coast_pol, q.cfg.clamp_pol,
                                 q.cfg.ext_clamp_en, q.cfg.pd};
        SEL_CLAMP:   d.prdata = {16'h0000, q.cfg.clamp_dur, q.cfg.clamp_dly};
        SEL_PLL:     d.prdata = {8'h00, q.cfg.hs_width, 4'h0, q.cfg.period};
        SEL_STATUS:  d.prdata = {28'h0000000, ls, q.clamp_out, coast_act, q.active};
        SEL_SYNCPOL: d.prdata = {24'h000000, q.cfg.ls_pol, 7'h00};
        default:     d.prdata = 32'h00000000;
      endcase
    end
    if (psel && penable && q.pready && pwrite) begin
      case (sel)
        SEL_CTRL: begin
          d.cfg.pd           = pwdata[`SCI_CTRL_PD];
          d.cfg.ext_clamp_en = pwdata[`SCI_CTRL_EXTERNAL_CLAMP_ENABLE];
          d.cfg.clamp_pol    = pwdata[`SCI_CTRL_CLMPPOL];
          d.cfg.coast_pol    = pwdata[`SCI_CTRL_COASTPOL];
          d.cfg.ext_clk_sel  = pwdata[`SCI_CTRL_EXTCK];
          d.cfg.hs_pol       = pwdata[`SCI_CTRL_HSPOL];
          d.cfg.slicer_sel   = pwdata[`SCI_CTRL_SLICESEL];
        end
        SEL_CLAMP: begin
          d.cfg.clamp_dly = pwdata[7:0];
          d.cfg.clamp_dur = pwdata[15:8];
        end
        SEL_PLL: begin
          d.cfg.period   = pwdata[11:0];
          d.cfg.hs_width = pwdata[23:16];
        end
        // [RULE4] polarity bit 7 of index 0x0F
        SEL_SYNCPOL: d.cfg.ls_pol = pwdata[`SCI_SYNCPOL_BIT];
        default: d.cfg = q.cfg;
      endcase
    end

    // [RULE1] idle timer restarts on any activity edge
    if (ev) begin
      d.idle_cnt = 16'h0000;
    end else if (q.idle_cnt < ACT_CYC) begin
      d.idle_cnt = q.idle_cnt + 16'h0001;
    end
    // [RULE2] low when idle or powered down
    d.active = ~q.cfg.pd & (d.idle_cnt < ACT_CYC);
    // [RULE3] outputs float with no activity
    d.oe_n   = ~d.active;

    // capture and data clock follow the sample enable
    if (pix_en) begin
      d.pix    = pix_in;
      d.dck    = ~q.dck;
      d.ls_dly = {q.ls_dly[0], ls};
    end

    // clamp timing
    if (q.cfg.ext_clamp_en) begin
      // [RULE6] pin honoured only when enabled
      d.clamp_st  = CLAMP_IDLE;
      d.clamp_cnt = 8'h00;
      d.clamp_out = ext_clamp_act;
    end else begin
      // [RULE7] [RULE19] internal delay then duration in pixel clocks
      unique case (q.clamp_st)
        CLAMP_IDLE: begin
          if (trail) begin
            d.clamp_st  = CLAMP_DELAY;
            d.clamp_cnt = 8'h00;
          end
        end
        CLAMP_DELAY: begin
          if (q.clamp_cnt == q.cfg.clamp_dly) begin
            d.clamp_st  = CLAMP_HOLD;
            d.clamp_cnt = 8'h00;
          end else if (pix_en) begin
            d.clamp_cnt = q.clamp_cnt + 8'h01;
          end
        end
        CLAMP_HOLD: begin
          if (q.clamp_cnt == q.cfg.clamp_dur) begin
            d.clamp_st  = CLAMP_IDLE;
          end else if (pix_en) begin
            d.clamp_cnt = q.clamp_cnt + 8'h01;
          end
        end
      endcase
      d.clamp_out = (d.clamp_st == CLAMP_HOLD);
    end

    // [RULE16] rebuilt line sync starts on a sample enable
    if (pix_en) begin
      if (q.hs_pend) begin
        d.hs_cnt  = q.cfg.hs_width;
        d.hs_pend = 1'b0;
      end else if (q.hs_cnt != 8'h00) begin
        d.hs_cnt = q.hs_cnt - 8'h01;
      end
    end
    if (lead) begin
      d.hs_pend = 1'b1;
    end
    d.hs_out = (d.hs_cnt != 8'h00) ~^ q.cfg.hs_pol;

    // [RULE17] [RULE18] slicer source select, green sync not inverted
    d.slicer = q.cfg.slicer_sel ? q.ls_dly[1] : pins_s[`SCI_IN_SOG];
  end

  // state register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      q          <= '0;
      q.cfg      <= CFG_RST;
      q.idle_cnt <= ACT_CYC;
      q.oe_n     <= 1'b1;
      q.hs_out   <= ~`SCI_RST_HSPOL;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register, pix_sample_en from the generator's register
  assign prdata            = q.prdata;
  assign pready            = q.pready;
  assign pslverr           = q.pslverr;
  assign chip_activity_out = q.active;
  assign pix_data_out      = q.pix;
  assign pix_data_oe_n     = q.oe_n;
  assign output_data_clock = q.dck;
  assign pix_sample_en     = pix_en;
  assign clamp_active_out  = q.clamp_out;
  assign line_sync_out     = q.hs_out;
  assign slicer_sync_out   = q.slicer;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  a_activity_event: assert property ( // [RULE1]
    (ev && !q.cfg.pd) |=> chip_activity_out)
    else $error("activity edge did not raise activity output");

  a_power_down_idle: assert property ( // [RULE2]
    q.cfg.pd |=> !chip_activity_out)
    else $error("activity output high in power-down");

  a_tristate_idle: assert property ( // [RULE3]
    !chip_activity_out |-> pix_data_oe_n)
    else $error("data driven while activity low");

  a_syncpol_write: assert property ( // [RULE4]
    (psel && penable && pready && pwrite && paddr == `SCI_ADDR_SYNCPOL)
      |=> q.cfg.ls_pol == $past(pwdata[`SCI_SYNCPOL_BIT]))
    else $error("line-sync polarity write lost");

  a_lead_edge: assert property ( // [RULE5]
    lead |-> (q.cfg.ls_pol ? $rose(ls) : $fell(ls)))
    else $error("leading edge taken on wrong transition");

  a_ext_clamp_on: assert property ( // [RULE6]
    (q.cfg.ext_clamp_en && ext_clamp_act) |=> clamp_active_out)
    else $error("enabled clamp pin not followed");

  a_clamp_internal: assert property ( // [RULE7]
    (!q.cfg.ext_clamp_en && trail && q.clamp_st == CLAMP_IDLE)
      |=> q.clamp_st == CLAMP_DELAY ##1 (q.clamp_st != CLAMP_IDLE))
    else $error("trailing edge did not start clamp delay");

  a_coast_hold: assert property ( // [RULE10]
    coast_act |-> !resync)
    else $error("generator realigned during coast");

  a_hs_start: assert property ( // [RULE16]
    (pix_en && q.hs_pend) |=> q.hs_cnt == $past(q.cfg.hs_width))
    else $error("rebuilt line sync width not loaded");

  a_slicer_green: assert property ( // [RULE18]
    !q.cfg.slicer_sel |=> slicer_sync_out == $past(pins_s[`SCI_IN_SOG]))
    else $error("slicer output not green sync");

endmodule : sci_top

`default_nettype wire

// ### verif/sci_src_model.sv
/*
  Behavioural graphics source: line sync pulses, data enable and external clock.
  Assumes core_clk paces it and the bench sets the run controls.
*/
`default_nettype none
module sci_src_model #(
  parameter int LINE_CYC = 100,
  parameter int SYNC_CYC = 30,
  parameter int EXT_HALF = 20
)
(
  input  wire logic core_clk,
  input  wire logic ls_run,
  input  wire logic ls_act_hi,
  input  wire logic de_run,
  input  wire logic ext_run,
  output logic      line_sync_in,
  output logic      active_video_flag,
  output logic      ext_clock_in,
  output int        line_pos
);
  int ext_cnt;

  // idle levels at time zero
  initial begin
    line_pos = 0;
    ext_cnt = 0;
    line_sync_in = 1'b0;
    active_video_flag = 1'b0;
    ext_clock_in = 1'b0;
  end

  // line timing; a stopped source rests at the inactive sync level
  always @(posedge core_clk) begin
    line_pos <= (line_pos == LINE_CYC - 1) ? 0 : line_pos + 1;
    line_sync_in <= (ls_run && line_pos < SYNC_CYC) ? ls_act_hi : !ls_act_hi;
    active_video_flag <= de_run && line_pos >= 40 && line_pos < 90;
    ext_cnt <= (ext_cnt == EXT_HALF - 1) ? 0 : ext_cnt + 1;
    if (!ext_run) begin
      ext_clock_in <= 1'b0;
    end else if (ext_cnt == EXT_HALF - 1) begin
      ext_clock_in <= !ext_clock_in;
    end
  end
endmodule : sci_src_model
`default_nettype wire

// ### verif/sci_top_tb.sv
/*
  Self-checking bench for sci_top: registers over APB, activity and tri-state,
  line-sync edge and polarity, clamp timing, slicer select, clock select and invert.
  Assumes zero-wait APB answers and the source model pacing line sync.
*/
`default_nettype none
`include "sci_consts.svh"
module sci_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        clamp_in, coast_in, green_in, inv_in, ls_run, ls_act_hi, de_run, ext_run;
  logic        line_sync_in, de_in, ext_clk_in, act, oe_n, pix_en, clamp_act, ls_out, slc;
  logic        dck, v;
  logic [23:0] pix_in, pix_out;
  logic [33:0] note;
  logic [33:0] notes[$];
  int          line_pos, error_cnt, checked, n, m;

  sci_top #(.ACT_TIMEOUT_CYC(150)) u_sci_top (
    .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_sync_in(line_sync_in), .active_video_flag(de_in), .clamp_in(clamp_in),
    .coast_in(coast_in), .green_embedded_sync_in(green_in), .ext_clock_in(ext_clk_in),
    .sampling_clock_invert(inv_in), .pix_in(pix_in), .chip_activity_out(act),
    .pix_data_out(pix_out), .pix_data_oe_n(oe_n), .output_data_clock(dck),
    .pix_sample_en(pix_en), .clamp_active_out(clamp_act), .line_sync_out(ls_out),
    .slicer_sync_out(slc));

  sci_src_model u_sci_src_model (
    .core_clk(core_clk), .ls_run(ls_run), .ls_act_hi(ls_act_hi), .de_run(de_run),
    .ext_run(ext_run), .line_sync_in(line_sync_in), .active_video_flag(de_in),
    .ext_clock_in(ext_clk_in), .line_pos(line_pos));

  // clock source
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic close_out;
    if (error_cnt == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  // one transfer; the note is judged by the monitor when pready comes
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic err, input logic [31:0] exp);
    notes.push_back({!wr, err, exp});
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_pos0;
    do begin
      @(posedge core_clk);
    end while (line_pos != 0);
  endtask : wait_pos0

  // cycles from the start of a line to the first sample enable
  task automatic first_en(output int k);
    wait_pos0();
    k = 0;
    while (pix_en !== 1'b1) begin
      @(posedge core_clk);
      k++;
    end
  endtask : first_en

  task automatic count_en(input int cyc, input logic in_clamp, output int c);
    c = 0;
    repeat (cyc) begin
      @(posedge core_clk);
      if (pix_en === 1'b1 && (!in_clamp || clamp_act === 1'b1)) c++;
    end
  endtask : count_en

  // cycles from a leading line-sync edge to the rebuilt sync going active
  task automatic lead_delay(output int k);
    wait_pos0();
    k = 0;
    while (ls_out !== 1'b1 && k < 60) begin
      @(posedge core_clk);
      k++;
    end
  endtask : lead_delay

  // bus monitor: takes the oldest note at each answer
  always @(posedge core_clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      note = notes.pop_front();
      if (note[33]) chk("prdata", prdata, note[31:0]);
      chk("pslverr", 32'(pslverr), 32'(note[32]));
    end
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    close_out();
  end

  // main sequence; coast pin low with coast polarity 1 and clamp pin low at the start, both driven high later
  // unused pins tied
  initial begin
    {psel, penable, pwrite, clamp_in, coast_in, green_in, inv_in, nrst} = '0;
    {ls_run, ls_act_hi, de_run, ext_run} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pix_in = 24'h0;
    void'($urandom(32'h59B0));
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    chk("activity", 32'(act), 0);
    chk("oe_n", 32'(oe_n), 1);
    apb(0, `SCI_ADDR_CTRL, 0, 0, 32'h0000_002C);
    apb(0, `SCI_ADDR_CLAMP, 0, 0, 32'h0000_0804);
    apb(0, `SCI_ADDR_PLL, 0, 0, 32'h0010_0009);
    apb(0, `SCI_ADDR_SYNCPOL, 0, 0, 32'h0000_0080);
    apb(0, 8'h10, 0, 1, 0);
    apb(1, 8'h10, 32'hFFFF_FFFF, 1, 0);
    apb(1, `SCI_ADDR_PLL, 32'h0002_0009, 0, 0);
    apb(1, `SCI_ADDR_CLAMP, 32'h0000_0301, 0, 0);
    apb(0, `SCI_ADDR_CLAMP, 0, 0, 32'h0000_0301);
    ls_run <= 1'b1;
    ls_act_hi <= 1'b1;
    repeat (300) @(posedge core_clk);
    chk("activity", 32'(act), 1);
    chk("oe_n", 32'(oe_n), 0);
    wait_pos0();
    pix_in <= 24'($urandom);
    repeat (60) @(posedge core_clk);
    chk("pix_data", 32'(pix_out), 32'(pix_in));
    for (int p = 1; p >= 0; p--) begin
      ls_act_hi <= p[0];
      apb(1, `SCI_ADDR_SYNCPOL, {24'h0, p[0], 7'h0}, 0, 0);
      repeat (250) @(posedge core_clk);
      lead_delay(n);
      chk("lead_edge", 32'(n >= 3 && n <= 25), 1);
    end
    apb(1, `SCI_ADDR_CTRL, 32'h0000_000C, 0, 0);
    wait_pos0();
    repeat (60) @(posedge core_clk);
    chk("hs_idle", 32'(ls_out), 1);
    apb(1, `SCI_ADDR_CTRL, 32'h0000_002C, 0, 0);
    clamp_in <= 1'b1;
    wait_pos0();
    count_en(100, 1, n);
    chk("clamp_len", n, 3);
    ls_run <= 1'b0;
    clamp_in <= 1'b0;
    repeat (300) @(posedge core_clk);
    chk("activity", 32'(act), 0);
    chk("oe_n", 32'(oe_n), 1);
    for (int p = 0; p < 2; p++) begin
      apb(1, `SCI_ADDR_CTRL, 32'h0000_002A | 32'(p << 2), 0, 0);
      clamp_in <= p[0];
      repeat (8) @(posedge core_clk);
      chk("ext_clamp_on", 32'(clamp_act), 1);
      clamp_in <= !p[0];
      repeat (8) @(posedge core_clk);
      chk("ext_clamp_off", 32'(clamp_act), 0);
    end
    clamp_in <= 1'b0;
    de_run <= 1'b1;
    apb(1, `SCI_ADDR_CTRL, 32'h0000_002C, 0, 0);
    repeat (300) @(posedge core_clk);
    chk("activity", 32'(act), 1);
    apb(1, `SCI_ADDR_CTRL, 32'h0000_002D, 0, 0);
    repeat (5) @(posedge core_clk);
    chk("activity", 32'(act), 0);
    chk("oe_n", 32'(oe_n), 1);
    apb(1, `SCI_ADDR_CTRL, 32'h0000_002C, 0, 0);
    de_run <= 1'b0;
    green_in <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk("slicer", 32'(slc), 1);
    green_in <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk("slicer", 32'(slc), 0);
    apb(1, `SCI_ADDR_CTRL, 32'h0000_006C, 0, 0);
    green_in <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      ls_act_hi <= p[0];
      repeat (40) @(posedge core_clk);
      chk("slicer_ls", 32'(slc), 32'(!p[0]));
    end
    green_in <= 1'b0;
    apb(1, `SCI_ADDR_CTRL, 32'h0000_002C, 0, 0);
    count_en(400, 0, n);
    chk("int_rate", n, 40);
    ext_run <= 1'b1;
    apb(1, `SCI_ADDR_CTRL, 32'h0000_003C, 0, 0);
    // invert moved only with line sync stopped
    for (int p = 0; p < 2; p++) begin
      inv_in <= p[0];
      repeat (100) @(posedge core_clk);
      count_en(400, 0, n);
      chk("ext_rate", n, 10);
      v = dck;
      while (pix_en !== 1'b1) @(posedge core_clk);
      chk("ext_edge", 32'(ext_clk_in), 32'(!p[0]));
      @(posedge core_clk);
      chk("data_clock", 32'(dck), 32'(!v));
    end
    // coast pin level against coast polarity
    ext_run <= 1'b0;
    ls_run <= 1'b1;
    apb(1, `SCI_ADDR_PLL, 32'h0002_000C, 0, 0);
    coast_in <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      apb(1, `SCI_ADDR_CTRL, 32'h0000_0024 | 32'(p << 3), 0, 0);
      repeat (200) @(posedge core_clk);
      first_en(n);
      first_en(m);
      chk("coast_track", 32'(n == m), 32'(p == 0));
    end
    close_out();
  end
endmodule : sci_top_tb
`default_nettype wire
